// *** hdl/tpr_pkg.sv ***
/*
 * tpr_pkg: shared types and constants for the test port reset and mode latch.
 * Assumes a single 50 MHz system clock; all pin levels are sampled by it.
 */
package tpr_pkg;

	// mode-select pair encodings
	localparam logic [1:0] MODE_SCAN    = 2'h0;
	localparam logic [1:0] MODE_EMUL    = 2'h3;
	localparam logic [1:0] MODE_RESET   = 2'h3;

	// synchroniser reset level: test reset pin reads low (pulldown) when idle
	localparam logic [2:0] SYNC_RESET   = 3'h0;
	localparam logic       ARMED_RESET  = 1'b0;
	localparam logic       VALID_RESET  = 1'b0;

	typedef enum logic [1:0] {
		TPR_TEST_RESET = 2'b00,
		TPR_WAIT_EDGE  = 2'b01,
		TPR_CONFIGURED = 2'b10
	} tpr_state_e;

	// sampled versions of the external pins
	typedef struct packed {
		logic       test_reset_n;
		logic       test_port_clock;
		logic [1:0] debug_mode_select_pair;
	} tpr_pins_s;

	// configuration handed to the test port
	typedef struct packed {
		logic       mode_valid;
		logic       boundary_scan_en;
		logic       emulation_en;
		logic [1:0] debug_mode_select_pair;
	} tpr_cfg_s;

endpackage

// *** hdl/tpr_sync.sv ***
/*
 * tpr_sync: two-flop synchroniser for a bundle of pin levels.
 * Assumes the inputs are asynchronous to sys_clk_i; the first stage feeds only the second.
 */
`timescale 1ns/10ps
module tpr_sync #(
	parameter int WIDTH = 4
) (
	input  wire logic             sys_clk_i,
	input  wire logic             reset_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] next_meta;
	logic [WIDTH-1:0] next_sync;

	always_comb begin
		next_meta = async_i;
		next_sync = meta;
		if (reset_i) begin
			next_meta = '0;
			next_sync = '0;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		meta   <= next_meta;
		sync_o <= next_sync;
	end
endmodule

// *** hdl/tpr_top.sv ***
/*
 * tpr_top: reset distribution and mode-select latch for the test and emulation port.
 * Assumes test_reset_n_i carries an internal pulldown at the pad and that the
 * external controller clocks the test reset with test_port_clock_i.
 */
// Summary of operation
// (RULE1) The system holds both system reset and test reset asserted at power-up.
// (RULE2) System reset initialises the core; test reset initialises emulation and test logic.
// (RULE3) Test reset is applied synchronously with running test port clock edges.
// (RULE4) Core boots when system reset alone is released; test reset release not needed.
// (RULE5) Held test reset keeps test port and emulation logic reset, core unaffected.
// (RULE6) Controller releases test reset only to debug or run boundary scan.
// (RULE7) Test reset input has an internal pulldown, asserted when left unconnected.
// (RULE8) Passive controllers assert test reset after power-up, then drive it high.
// (RULE9) After system reset release, mode pins are captured on next test reset rise.
// (RULE10) Captured mode pair selects boundary-scan mode or emulation mode.
// (RULE11) While system reset is low, internal core reset is held asserted.
// (RULE12) Captured mode stays stable until the next qualifying test reset rise.
`timescale 1ns/10ps
module tpr_top (
	input  wire logic       sys_clk_i,
	input  wire logic       reset_i,
	input  wire logic       sys_reset_n_i,
	input  wire logic       test_reset_n_i,
	input  wire logic       test_port_clock_i,
	input  wire logic       debug_mode_select_hi_i,
	input  wire logic       debug_mode_select_lo_i,
	output logic            internal_pulldown_o,
	output logic            core_reset_o,
	output logic            test_logic_reset_o,
	output logic            test_port_clock_rise_o,
	output logic            mode_valid_o,
	output logic            boundary_scan_en_o,
	output logic            emulation_en_o,
	output logic [1:0]      debug_mode_select_pair_o
);
	tpr_pkg::tpr_pins_s pins_raw;
	tpr_pkg::tpr_pins_s pins;
	logic               sys_reset_n;
	logic               sys_rst_sync;

	tpr_pkg::tpr_state_e state;
	tpr_pkg::tpr_state_e next_state;
	logic                trst_prev;
	logic                next_trst_prev;
	logic                test_port_clock_prev;
	logic                next_test_port_clock_prev;
	tpr_pkg::tpr_cfg_s   cfg;
	tpr_pkg::tpr_cfg_s   next_cfg;
	logic                core_reset;
	logic                next_core_reset;
	logic                test_reset;
	logic                next_test_reset;
	logic                trst_rise;
	logic                armed_rise;
	logic                scan_en;
	logic                next_scan_en;
	logic                emul_en;
	logic                next_emul_en;

	// the pad pulldown is a static strap request; kept on at all times
	assign internal_pulldown_o = 1'b1; // [RULE7]

	assign pins_raw.test_reset_n           = test_reset_n_i;
	assign pins_raw.test_port_clock        = test_port_clock_i;
	assign pins_raw.debug_mode_select_pair = {debug_mode_select_hi_i, debug_mode_select_lo_i};

	tpr_sync #(
		.WIDTH($bits(tpr_pkg::tpr_pins_s) + 1)
	) u_sync (
		.sys_clk_i(sys_clk_i),
		.reset_i  (reset_i),
		.async_i  ({pins_raw, sys_reset_n_i}),
		.sync_o   ({pins, sys_rst_sync})
	);
	assign sys_reset_n = sys_rst_sync;

	assign trst_rise = pins.test_reset_n & ~trst_prev;
	// one qualifying rise: armed, core out of reset, test reset seen rising
	assign armed_rise = (state == tpr_pkg::TPR_WAIT_EDGE) && sys_reset_n && trst_rise;

	always_comb begin
		next_trst_prev  = pins.test_reset_n;
		next_test_port_clock_prev  = pins.test_port_clock;
		next_state      = state;
		next_cfg        = cfg;
		// core reset follows system reset only; test reset plays no part [RULE4] [RULE11]
		next_core_reset = ~sys_reset_n; // [RULE2]
		// test logic reset follows the test reset pin only; core keeps running [RULE5]
		next_test_reset = ~pins.test_reset_n; // [RULE2]
		case (state)
			tpr_pkg::TPR_TEST_RESET: begin
				// rising edges while the core is still in reset are not qualifying
				if (sys_reset_n && !pins.test_reset_n) begin
					next_state = tpr_pkg::TPR_WAIT_EDGE;
				end
			end
			tpr_pkg::TPR_WAIT_EDGE: begin
				if (!sys_reset_n) begin
					next_state = tpr_pkg::TPR_TEST_RESET;
				end else if (trst_rise) begin
					next_cfg.debug_mode_select_pair = pins.debug_mode_select_pair; // [RULE9]
					next_cfg.mode_valid             = 1'b1;
					next_cfg.emulation_en           =
						(pins.debug_mode_select_pair == tpr_pkg::MODE_EMUL); // [RULE10]
					next_cfg.boundary_scan_en       =
						(pins.debug_mode_select_pair == tpr_pkg::MODE_SCAN); // [RULE10]
					next_state = tpr_pkg::TPR_CONFIGURED;
				end
			end
			tpr_pkg::TPR_CONFIGURED: begin
				// mode pins are ignored here; only a new arm-and-rise reloads [RULE12]
				if (!sys_reset_n) begin
					next_state = tpr_pkg::TPR_TEST_RESET;
				end else if (!pins.test_reset_n) begin
					next_state = tpr_pkg::TPR_WAIT_EDGE;
				end
			end
			default: begin
				next_state = tpr_pkg::TPR_TEST_RESET;
			end
		endcase
		if (reset_i) begin
			next_state      = tpr_pkg::TPR_TEST_RESET;
			next_cfg        = '0;
			next_trst_prev  = tpr_pkg::ARMED_RESET;
			next_test_port_clock_prev  = 1'b0;
			next_core_reset = 1'b1;
			next_test_reset = 1'b1;
		end
		// enables registered so the port sees clean levels; reset forces them low
		next_scan_en = next_cfg.boundary_scan_en & ~next_test_reset; // [RULE5]
		next_emul_en = next_cfg.emulation_en & ~next_test_reset;
	end

	always_ff @(posedge sys_clk_i) begin
		state      <= next_state;
		cfg        <= next_cfg;
		trst_prev  <= next_trst_prev;
		test_port_clock_prev  <= next_test_port_clock_prev;
		core_reset <= next_core_reset;
		test_reset <= next_test_reset;
		scan_en    <= next_scan_en;
		emul_en    <= next_emul_en;
	end

	assign core_reset_o             = core_reset;
	assign test_logic_reset_o       = test_reset;
	// test logic is clocked by test clock edges found here; a stopped clock stalls it
	assign test_port_clock_rise_o   = pins.test_port_clock & ~test_port_clock_prev & ~test_reset; // [RULE3]
	assign mode_valid_o             = cfg.mode_valid;
	// while test reset is held the port stays in reset, so neither mode enable is raised
	assign boundary_scan_en_o       = scan_en; // [RULE5]
	assign emulation_en_o           = emul_en;
	assign debug_mode_select_pair_o = cfg.debug_mode_select_pair;

	property p_core_follows;
		@(posedge sys_clk_i) disable iff (reset_i)
		!sys_reset_n |=> core_reset;
	endproperty
	a_core_reset_hold: assert property (p_core_follows) // [RULE11]
		else $error("core reset not held with system reset low");

	a_boot_indep_trst: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		(sys_reset_n && !pins.test_reset_n) |=> !core_reset) // [RULE4]
		else $error("core held in reset by test reset");

	a_test_reset_hold: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		!pins.test_reset_n |=> (test_reset && !boundary_scan_en_o && !emulation_en_o)) // [RULE5]
		else $error("test logic not held in reset");

	sequence s_armed_rise;
		(state == tpr_pkg::TPR_WAIT_EDGE) && sys_reset_n && trst_rise;
	endsequence
	a_mode_capture: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		s_armed_rise |=> (cfg.mode_valid
		&& cfg.debug_mode_select_pair == $past(pins.debug_mode_select_pair))) // [RULE9]
		else $error("mode pair not captured on test reset rise");

	a_mode_decode: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		cfg.mode_valid |-> (cfg.emulation_en == (cfg.debug_mode_select_pair == tpr_pkg::MODE_EMUL)
		&& cfg.boundary_scan_en == (cfg.debug_mode_select_pair == tpr_pkg::MODE_SCAN))) // [RULE10]
		else $error("mode decode mismatch");

	a_mode_stable: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		!armed_rise |=> $stable(cfg.debug_mode_select_pair)) // [RULE12]
		else $error("captured mode changed without qualifying edge");

	a_pulldown_on: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		internal_pulldown_o) // [RULE7]
		else $error("pulldown request dropped");

	a_tck_gated: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		test_port_clock_rise_o |-> (!test_reset && !test_port_clock_prev)) // [RULE3]
		else $error("test clock edge passed in reset");

	a_tck_pulse_single: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		test_port_clock_rise_o |=> !test_port_clock_rise_o) // [RULE3]
		else $error("test clock edge pulse longer than one cycle");

	a_enable_excl: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		!(boundary_scan_en_o && emulation_en_o)) // [RULE10]
		else $error("both port modes enabled");

	a_enable_mode: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		(boundary_scan_en_o || emulation_en_o) |-> mode_valid_o) // [RULE10]
		else $error("mode enabled without a captured pair");

	sequence s_arm;
		(state == tpr_pkg::TPR_TEST_RESET) && sys_reset_n && !pins.test_reset_n;
	endsequence
	a_arm_step: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		s_arm |=> (state == tpr_pkg::TPR_WAIT_EDGE)) // [RULE9]
		else $error("latch not armed after system reset release");

	a_arm_refused: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		(state == tpr_pkg::TPR_TEST_RESET) && !sys_reset_n |=> (state == tpr_pkg::TPR_TEST_RESET)) // [RULE9]
		else $error("latch armed during system reset");

	a_no_early_capture: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		(state != tpr_pkg::TPR_WAIT_EDGE) |=> $stable(cfg)) // [RULE9]
		else $error("mode captured while not armed");

	a_trst_release: assert property (@(posedge sys_clk_i) disable iff (reset_i)
		pins.test_reset_n |=> !test_reset) // [RULE2]
		else $error("test logic kept in reset after release");
endmodule

// *** tb/tpr_jtag_model.sv ***
/*
 * tpr_jtag_model: behavioural external test port controller.
 * Assumes it is paced by the falling edge of the bench system clock.
 */
`timescale 1ns/10ps
module tpr_jtag_model (
	input  wire logic sys_clk_i,
	output logic      test_reset_n_o,
	output logic      test_port_clock_o,
	output logic      debug_mode_select_hi_o,
	output logic      debug_mode_select_lo_o
);
	logic drive_en;
	logic trst_level;
	// pin left floating reads as the pad pulldown level
	assign test_reset_n_o = drive_en ? trst_level : 1'b0;
	initial begin
		drive_en = 1'b0;
		trst_level = 1'b0;
		test_port_clock_o = 1'b0;
		{debug_mode_select_hi_o, debug_mode_select_lo_o} = 2'h0;
	end
	// 160 ns test clock; it stands low between bursts
	task automatic clocks(input int n);
		for (int i = 0; i < n; i++) begin
			repeat (4) @(negedge sys_clk_i);
			test_port_clock_o = 1'b1;
			repeat (4) @(negedge sys_clk_i);
			test_port_clock_o = 1'b0;
		end
	endtask
	// test reset always moves while the clock stands low; two clock periods follow
	task automatic set_trst(input logic lvl);
		drive_en = 1'b1;
		trst_level = lvl;
		clocks(2);
	endtask
	task automatic set_mode(input logic [1:0] m);
		{debug_mode_select_hi_o, debug_mode_select_lo_o} = m;
	endtask
endmodule

// *** tb/tpr_top_tb.sv ***
/*
 * tpr_top_tb: directed bench for reset distribution and mode latch.
 * Assumes the designer's latencies of at most four system clock edges.
 */
`timescale 1ns/10ps
module tpr_top_tb;
	logic       clk, reset, sys_reset_n, trst_n, tck, hi, lo;
	logic       pd, core_rst, tl_rst, rise, valid, scan, emul;
	logic [1:0] pair;
	int         mismatches, compares, rise_cnt;
	tpr_jtag_model tpr_jtag_model_i (.sys_clk_i(clk), .test_reset_n_o(trst_n),
		.test_port_clock_o(tck), .debug_mode_select_hi_o(hi), .debug_mode_select_lo_o(lo));
	tpr_top tpr_top_i (.sys_clk_i(clk), .reset_i(reset), .sys_reset_n_i(sys_reset_n),
		.test_reset_n_i(trst_n), .test_port_clock_i(tck), .debug_mode_select_hi_i(hi),
		.debug_mode_select_lo_i(lo), .internal_pulldown_o(pd), .core_reset_o(core_rst),
		.test_logic_reset_o(tl_rst), .test_port_clock_rise_o(rise), .mode_valid_o(valid),
		.boundary_scan_en_o(scan), .emulation_en_o(emul), .debug_mode_select_pair_o(pair));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// counted on the falling edge: the pulse is launched by the rising one
	always @(negedge clk) if (rise === 1'b1) rise_cnt++;
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic summarize();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic t_power();
		check("core_reset", 8'h1, core_rst);
		check("test_logic_reset", 8'h1, tl_rst);
		check("mode_valid", 8'h0, valid);
		check("pulldown", 8'h1, pd);
		$display("t_power done");
	endtask
	task automatic t_boot();
		sys_reset_n = 1'b1;
		wait_cyc(6);
		check("core_reset", 8'h0, core_rst);
		check("test_logic_reset", 8'h1, tl_rst);
		check("enables", 8'h0, {scan, emul});
		$display("t_boot done");
	endtask
	// every pair code, then pins move while the latch must hold
	task automatic t_capture(input logic [1:0] m);
		tpr_jtag_model_i.set_mode(m);
		// mode pins settle before the test reset rise that latches them
		wait_cyc(2);
		tpr_jtag_model_i.set_trst(1'b1);
		check("pair", {6'h0, m}, pair);
		check("mode_valid", 8'h1, valid);
		check("scan_en", {7'h0, m == tpr_pkg::MODE_SCAN}, scan);
		check("emul_en", {7'h0, m == tpr_pkg::MODE_EMUL}, emul);
		check("test_logic_reset", 8'h0, tl_rst);
		check("core_reset", 8'h0, core_rst);
		tpr_jtag_model_i.set_mode(~m);
		wait_cyc(6);
		check("pair_held", {6'h0, m}, pair);
		tpr_jtag_model_i.set_trst(1'b0);
		check("test_logic_reset", 8'h1, tl_rst);
		check("enables", 8'h0, {scan, emul});
		$display("t_capture %0h done", m);
	endtask
	// a rise during system reset must not latch
	task automatic t_refuse();
		sys_reset_n = 1'b0;
		tpr_jtag_model_i.set_mode(2'h1);
		tpr_jtag_model_i.set_trst(1'b1);
		check("core_reset", 8'h1, core_rst);
		sys_reset_n = 1'b1;
		wait_cyc(6);
		check("pair_kept", 8'h3, pair);
		$display("t_refuse done");
	endtask
	task automatic t_clock();
		rise_cnt = 0;
		tpr_jtag_model_i.clocks(3);
		wait_cyc(4);
		check("clock_rises", 8'h3, rise_cnt[7:0]);
		tpr_jtag_model_i.set_trst(1'b0);
		rise_cnt = 0;
		tpr_jtag_model_i.clocks(3);
		wait_cyc(4);
		check("rises_in_reset", 8'h0, rise_cnt[7:0]);
		$display("t_clock done");
	endtask
	// a second reset mid-run clears the latch; the port re-arms and captures again
	task automatic t_midreset();
		reset = 1'b1;
		wait_cyc(3);
		check("core_reset", 8'h1, core_rst);
		check("test_logic_reset", 8'h1, tl_rst);
		check("mode_valid", 8'h0, valid);
		check("pair", 8'h0, pair);
		reset = 1'b0;
		wait_cyc(6);
		check("core_reset", 8'h0, core_rst);
		check("test_logic_reset", 8'h1, tl_rst);
		tpr_jtag_model_i.set_mode(2'h2);
		wait_cyc(2);
		tpr_jtag_model_i.set_trst(1'b1);
		check("pair", 8'h2, pair);
		check("mode_valid", 8'h1, valid);
		check("enables", 8'h0, {scan, emul});
		$display("t_midreset done");
	endtask
	initial begin
		#1000000;
		mismatches++;
		summarize();
	end
	initial begin
		mismatches = 0;
		compares = 0;
		rise_cnt = 0;
		reset = 1'b1;
		sys_reset_n = 1'b0;
		wait_cyc(8);
		reset = 1'b0;
		wait_cyc(4);
		t_power();
		t_boot();
		for (int m = 0; m < 4; m++) t_capture(m[1:0]);
		t_refuse();
		t_clock();
		t_midreset();
		summarize();
	end
endmodule
